/* rrs_core.sv */
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module rrs_core
   import rrs_pkg::*;
#(
   parameter int IP_W = 13,
   parameter int STACK_DEPTH = 8,
   parameter int FREGS = 128,
   parameter int PRE_W = 8
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic wake,
   output logic sleeping
);

   localparam int SP_W = $clog2(STACK_DEPTH);
   localparam int FA_W = $clog2(FREGS);

   // ----------------------------------------
   // state
   // ----------------------------------------
   rrs_state_e state;
   rrs_cmd_s cmd;
   logic [7:0] acc;
   logic carry;
   logic pwrdn_flag;
   logic to_flag;
   logic [IP_W-1:0] iptr;
   logic [IP_W-1:0] stack [STACK_DEPTH];
   logic [SP_W-1:0] sp;
   logic [7:0] fregs [FREGS];
   logic [FA_W-1:0] faddr;
   logic [PRE_W-1:0] wdog_pre;
   logic [7:0] wdog_cnt;
   logic wake_m;
   logic wake_s;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire idle = (state == ST_IDLE);
   wire acc_phase = psel & penable & ~pready;
   wire take = psel & penable & pready;
   wire wr_ok = take & pwrite & ~pslverr;
   wire hit_acc = (paddr == OFS_ACC);
   wire hit_stat = (paddr == OFS_STATUS);
   wire hit_ip = (paddr == OFS_IPTR);
   wire hit_push = (paddr == OFS_PUSH);
   wire hit_cmd = (paddr == OFS_CMD);
   wire hit_fa = (paddr == OFS_FADDR);
   wire hit_fd = (paddr == OFS_FDATA);
   wire hit_wd = (paddr == OFS_WDOG);
   wire mapped = hit_acc | hit_stat | hit_ip | hit_push | hit_cmd | hit_fa | hit_fd | hit_wd;
   // writes only land while idle, so software never races the executing op
   wire refuse = ~mapped | (pwrite & ~idle);
   // status bits placed by their field positions; unused bits read zero
   logic [7:0] stat_byte;
   always_comb begin
      stat_byte = 8'h00;
      stat_byte[STAT_CARRY] = carry;
      stat_byte[STAT_PWRDN] = pwrdn_flag;
      stat_byte[STAT_TO] = to_flag;
   end

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      if (hit_acc) begin
         rd_mux = {24'h0, acc};
      end else if (hit_stat) begin
         rd_mux = {24'h0, stat_byte};
      end else if (hit_ip) begin
         rd_mux = {{(32-IP_W){1'b0}}, iptr};
      end else if (hit_push) begin
         rd_mux = {{(32-SP_W){1'b0}}, sp};
      end else if (hit_cmd) begin
         rd_mux = {28'h0, state};
      end else if (hit_fa) begin
         rd_mux = {{(32-FA_W){1'b0}}, faddr};
      end else if (hit_fd) begin
         rd_mux = {24'h0, fregs[faddr]};
      end else if (hit_wd) begin
         rd_mux = {{(24-PRE_W){1'b0}}, wdog_pre, wdog_cnt};
      end
   end

   // ----------------------------------------
   // execution datapath
   // ----------------------------------------
   wire exec = (state == ST_EXEC);
   wire [SP_W-1:0] sp_pop = sp - 1'b1;
   wire [IP_W-1:0] stack_head = stack[sp_pop];
   wire is_ret = (cmd.op == OP_RETLIT) | (cmd.op == OP_RETURN);
   wire [FA_W-1:0] rot_idx = cmd.arg[FA_W-1:0];
   wire [7:0] rot_src = fregs[rot_idx];
   wire [7:0] rot_res = {rot_src[6:0], carry};
   wire rot_carry = rot_src[7];
   wire do_rot = exec & (cmd.op == OP_ROTL);
   wire do_sleep = exec & (cmd.op == OP_SLEEP);
   wire do_pop = exec & is_ret;

   rrs_state_e next_state;
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (wr_ok & hit_cmd) begin
               next_state = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (is_ret) begin
               next_state = ST_FLUSH;
            end else if (cmd.op == OP_SLEEP) begin
               next_state = ST_SLEEP;
            end else begin
               next_state = ST_IDLE;
            end
         end
         ST_FLUSH: begin
            next_state = ST_IDLE;
         end
         ST_SLEEP: begin
            if (wake_s) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // ----------------------------------------
   // bus response, one wait state
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= acc_phase;
         pslverr <= acc_phase & refuse;
         prdata <= (acc_phase & ~pwrite & mapped) ? rd_mux : 32'h0;
      end
   end

   // ----------------------------------------
   // control and flags
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         state <= ST_IDLE;
         sleeping <= 1'b0;
      end else begin
         state <= next_state;
         sleeping <= (next_state == ST_SLEEP);
      end
   end

   // ----------------------------------------
   // wake synchroniser
   // ----------------------------------------
   // wake comes from outside the clock domain; only wake_s is read by logic
   always_ff @(posedge clock) begin
      if (rst) begin
         wake_m <= 1'b0;
         wake_s <= 1'b0;
      end else begin
         wake_m <= wake;
         wake_s <= wake_m;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cmd <= '0;
      end else if (wr_ok & hit_cmd) begin
         cmd <= pwdata[CMD_OP_LSB+1:CMD_ARG_LSB];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         acc <= RST_ACC;
      end else if (wr_ok & hit_acc) begin
         acc <= pwdata[7:0];
      end else if (do_rot & (cmd.dest == DEST_ACC)) begin
         acc <= rot_res;
      end else if (exec & (cmd.op == OP_RETLIT)) begin
         acc <= cmd.arg;
      end
   end

   // returns and sleep leave carry alone; rotate changes only carry
   always_ff @(posedge clock) begin
      if (rst) begin
         carry <= RST_CARRY;
      end else if (wr_ok & hit_stat) begin
         carry <= pwdata[STAT_CARRY];
      end else if (do_rot) begin
         carry <= rot_carry;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pwrdn_flag <= RST_PWRDN;
      end else if (do_sleep) begin
         pwrdn_flag <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         to_flag <= RST_TO;
      end else if (do_sleep) begin
         to_flag <= 1'b1;
      end
   end

   // ----------------------------------------
   // instruction pointer and return stack
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         iptr <= '0;
         sp <= '0;
      end else if (wr_ok & hit_ip) begin
         iptr <= pwdata[IP_W-1:0];
      end else if (wr_ok & hit_push) begin
         sp <= sp + 1'b1;
      end else if (do_pop) begin
         iptr <= stack_head;
         sp <= sp_pop;
      end else if (do_rot | do_sleep) begin
         iptr <= iptr + 1'b1;
      end
   end

   // the stack wraps like a ring; overflow silently overwrites the oldest entry
   always_ff @(posedge clock) begin
      if (wr_ok & hit_push) begin
         stack[sp] <= pwdata[IP_W-1:0];
      end
   end

   // ----------------------------------------
   // file registers
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         faddr <= '0;
      end else if (wr_ok & hit_fa) begin
         faddr <= pwdata[FA_W-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (wr_ok & hit_fd) begin
         fregs[faddr] <= pwdata[7:0];
      end else if (do_rot & (cmd.dest == DEST_FILE)) begin
         fregs[rot_idx] <= rot_res;
      end
   end

   // ----------------------------------------
   // watchdog
   // ----------------------------------------
   // keeps counting in sleep: it stands for a timer on its own oscillator
   always_ff @(posedge clock) begin
      if (rst) begin
         wdog_pre <= '0;
         wdog_cnt <= 8'h00;
      end else if (do_sleep) begin
         wdog_pre <= '0;
         wdog_cnt <= 8'h00;
      end else begin
         wdog_pre <= wdog_pre + 1'b1;
         if (&wdog_pre) begin
            wdog_cnt <= wdog_cnt + 1'b1;
         end
      end
   end

endmodule

/* rrs_pkg.sv */
// Notes on behaviour
// - return-with-literal loads its 8-bit literal into the accumulator
// - return-with-literal pops the stack; instruction pointer takes the stack head
// - return-with-literal is one word, two cycles, status flags untouched
// - plain return pops stack into instruction pointer, two cycles, flags untouched
// - rotate left shifts register through carry: old carry in, old bit 7 out
// - rotate destination 0 writes accumulator, 1 writes the addressed file register
// - rotate is one word, one cycle, and alters only the carry flag
// - sleep clears the watchdog count and its prescaler
// - sleep clears the powerdown flag
// - sleep sets the timeout flag and touches no status bit other than powerdown
// - after sleep nothing executes until a wake-up event
package rrs_pkg;

   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_ACC = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IPTR = 8'h08;
   localparam logic [7:0] OFS_PUSH = 8'h0c;
   localparam logic [7:0] OFS_CMD = 8'h10;
   localparam logic [7:0] OFS_FADDR = 8'h14;
   localparam logic [7:0] OFS_FDATA = 8'h18;
   localparam logic [7:0] OFS_WDOG = 8'h1c;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int STAT_CARRY = 0;
   localparam int STAT_PWRDN = 3;
   localparam int STAT_TO = 4;
   localparam int CMD_ARG_LSB = 0;
   localparam int CMD_DEST = 8;
   localparam int CMD_OP_LSB = 9;
   localparam int WDOG_PRE_LSB = 8;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic RST_CARRY = 1'b0;
   localparam logic RST_PWRDN = 1'b1;
   localparam logic RST_TO = 1'b1;
   localparam logic [7:0] RST_ACC = 8'h00;

   // ----------------------------------------
   // command codes and types
   // ----------------------------------------
   localparam logic [1:0] OP_RETLIT = 2'h0;
   localparam logic [1:0] OP_RETURN = 2'h1;
   localparam logic [1:0] OP_ROTL = 2'h2;
   localparam logic [1:0] OP_SLEEP = 2'h3;
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   typedef struct packed {
      logic [1:0] op;
      logic dest;
      logic [7:0] arg;
   } rrs_cmd_s;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_EXEC = 4'b0010,
      ST_FLUSH = 4'b0100,
      ST_SLEEP = 4'b1000
   } rrs_state_e;

endpackage

/* rrs_core_sva.sv */
`timescale 1ns/1ps
module rrs_core_chk
   import rrs_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic wake,
   input wire logic sleeping
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire acc_ph = psel && penable;
   sequence s_sleep_cmd;
      acc_ph && pready && !pslverr && pwrite && paddr == OFS_CMD
         && pwdata[CMD_OP_LSB+:2] == OP_SLEEP;
   endsequence
   sequence s_quiet;
      !wake [*3];
   endsequence
   a_ready_wait: assert property (acc_ph && !pready |=> pready)
      else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready too long");
   a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("bad error reply");
   a_ready_cause: assert property (pready |-> $past(acc_ph))
      else $error("pready without access");
   a_unmapped_err: assert property (acc_ph && pready && paddr > OFS_WDOG |-> pslverr)
      else $error("unmapped not refused");
   a_sleep_entry: assert property (s_sleep_cmd |-> ##[2:3] sleeping)
      else $error("no sleep");
   a_sleep_holds: assert property (s_quiet ##0 sleeping |=> sleeping)
      else $error("left sleep");
   a_wake_exit: assert property ($rose(wake) && sleeping |-> ##[1:4] !sleeping)
      else $error("no wake");
endmodule
bind rrs_core rrs_core_chk u_chk (.clock, .rst, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .wake, .sleeping);

/* tb.sv */
`timescale 1ns/1ps
module tb;
   import rrs_pkg::*;
   logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, wake = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, sleeping, er;
   int err_count = 0, checked = 0;
   always #10 clock = ~clock;
   rrs_core u_rrs_core (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .wake, .sleeping);
   // ----------------
   // bus and checks
   // ----------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      // no wait limit here: a slave that never answers is caught by the watchdog
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clock);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(0, a, 0);
      chk(rd, e);
   endtask
   // one exec plus flush is over before the three idle edges pass
   task automatic cmd(input logic [1:0] op, input logic dst, input logic [7:0] arg);
      apb(1, OFS_CMD, {21'h0, op, dst, arg});
      repeat (3) @(posedge clock);
   endtask
   // ----------------
   // scenarios
   // ----------------
   task automatic t_ret;
      rdc(OFS_STATUS, 32'h18);
      apb(1, OFS_STATUS, 32'h1);
      apb(1, OFS_PUSH, 32'h0123);
      apb(1, OFS_PUSH, 32'h1abc);
      cmd(OP_RETLIT, 0, 8'hff);
      rdc(OFS_ACC, 32'hff);
      rdc(OFS_IPTR, 32'h1abc);
      rdc(OFS_PUSH, 32'h1);
      rdc(OFS_STATUS, 32'h19);
      cmd(OP_RETURN, 0, 8'h5a);
      rdc(OFS_IPTR, 32'h0123);
      rdc(OFS_ACC, 32'hff);
      rdc(OFS_STATUS, 32'h19);
      $display("returns done");
   endtask
   task automatic t_rot;
      apb(1, OFS_STATUS, 32'h0);
      apb(1, OFS_FADDR, 32'h7f);
      apb(1, OFS_FDATA, 32'he6);
      apb(1, OFS_IPTR, 32'h10);
      cmd(OP_ROTL, DEST_ACC, 8'h7f);
      rdc(OFS_ACC, 32'hcc);
      rdc(OFS_FDATA, 32'he6);
      rdc(OFS_STATUS, 32'h19);
      rdc(OFS_IPTR, 32'h11);
      cmd(OP_ROTL, DEST_FILE, 8'h7f);
      rdc(OFS_FDATA, 32'hcd);
      rdc(OFS_ACC, 32'hcc);
      rdc(OFS_STATUS, 32'h19);
      $display("rotate done");
   endtask
   task automatic t_sleep;
      cmd(OP_SLEEP, 0, 8'h0);
      // prescaler restarts at the sleep cycle; four edges pass before the read samples it
      rdc(OFS_WDOG, 32'h0400);
      chk(sleeping, 1);
      apb(1, OFS_ACC, 32'h5);
      chk(er, 1);
      rdc(OFS_ACC, 32'hcc);
      rdc(OFS_STATUS, 32'h11);
      wake <= 1;
      repeat (6) @(posedge clock);
      wake <= 0;
      chk(sleeping, 0);
      rdc(OFS_IPTR, 32'h13);
      apb(0, 8'h20, 0);
      chk(er, 1);
      chk(rd, 0);
      $display("sleep done");
   endtask
   task automatic give_verdict;
      $display("mismatches %0d comparisons %0d", err_count, checked);
      if (err_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clock);
      rst <= 0;
      @(posedge clock);
      t_ret();
      t_rot();
      t_sleep();
      give_verdict();
   end
   initial begin
      #100000;
      err_count++;
      give_verdict();
   end
endmodule
